// ===== logic/switch_global_control_regs.sv
// Global control registers: host-side port, storm rate, counter control
`timescale 1ns/1ps
`default_nettype none
module switch_global_control_regs
    import sw_ctrl_pkg::*;
#(
    parameter int P100_CYC = sw_ctrl_pkg::PERIOD_100_CYC,
    parameter int P10_CYC = sw_ctrl_pkg::PERIOD_10_CYC
) (
    input wire logic clk_sys_i,                       // Core clock
    input wire logic reset_n_i,                       // Sync reset, low
    input wire logic [7:0] reg_addr_i,                // Register offset
    input wire logic [7:0] reg_wdata_i,               // Write data
    input wire logic reg_wr_i,                        // Write strobe
    input wire logic reg_rd_i,                        // Read strobe
    output logic [7:0] reg_rdata_o,                   // Read data
    output logic reg_rvalid_o,                        // Read data valid
    output sw_ctrl_pkg::host_cfg_t host_cfg_o,        // Host port config
    input wire logic vid_valid_i,                     // Tag VID valid
    input wire logic [sw_ctrl_pkg::VID_W-1:0] vid_i,  // Received VID
    input wire logic [sw_ctrl_pkg::VID_W-1:0] port_vid_i, // Port VID
    output logic vid_valid_o,                         // Result valid
    output logic [sw_ctrl_pkg::VID_W-1:0] vid_o,      // Resulting VID
    input wire logic [4:0] bcast_block_i,             // Block seen, pulse
    input wire logic [4:0] port_storm_en_i,           // Per-port enable
    input wire logic [4:0] port_speed_10_i,           // Port at 10 Mb/s
    output logic [4:0] bcast_drop_o,                  // Drop block, pulse
    input wire logic mib_evt_i,                       // Count event
    input wire logic [2:0] mib_evt_port_i,            // Event port
    input wire logic [5:0] mib_evt_idx_i,             // Event counter
    input wire logic mib_rd_i,                        // Counter read
    input wire logic [2:0] mib_rd_port_i,             // Read port
    input wire logic [5:0] mib_rd_idx_i,              // Read counter
    output logic mib_rd_valid_o,                      // Read data valid
    output logic [sw_ctrl_pkg::MIB_DW-1:0] mib_rd_data_o, // Read data
    output logic mib_flush_busy_o                     // Flush running
);
    import sw_ctrl_pkg::*;

    // Port selected by the flush/freeze mask
    function automatic logic is_selected(input logic [2:0] port,
                                         input logic [4:0] mask);
        is_selected = (port < 3'(NUM_PORTS)) && mask[port];
    endfunction

    logic [7:0] hp_reg, hp_next, rlow_reg, rlow_next;
    logic [7:0] sc_reg, sc_next, rdata_next;
    logic rvalid_next;
    logic wr_hp, wr_rl, wr_sc;
    host_cfg_t cfg_next;
    logic vidv_next;
    logic [VID_W-1:0] vid_next;
    logic [RATE_W-1:0] rate;

    assign wr_hp = reg_wr_i && (reg_addr_i == HOST_PORT_AND_STORM_HIGH_OFS);
    assign wr_rl = reg_wr_i && (reg_addr_i == STORM_RATE_LOW_OFS);
    assign wr_sc = reg_wr_i && (reg_addr_i == STAT_COUNTER_CONTROL_OFS);
    assign rate = {hp_reg[HP_RATE_HI_MSB:0], rlow_reg};

    flush_state_t fl_reg, fl_next;
    logic [MIB_AW-1:0] fl_addr_reg, fl_addr_next;
    logic fl_wr, fl_last, evt_take, rd_take;
    logic inc_pend_reg, inc_pend_next, fwd_reg, fwd_next;
    logic [MIB_AW-1:0] inc_addr_reg, inc_addr_next, evt_addr, ram_rd_addr;
    logic [MIB_DW-1:0] last_wr_reg, last_wr_next, ram_rd_data, inc_data;
    logic ram_wr_en;
    logic [MIB_AW-1:0] ram_wr_addr;
    logic [MIB_DW-1:0] ram_wr_data;
    logic rd_pend_reg, rd_pend_next, mrv_next, busy_next;
    logic [MIB_DW-1:0] mrd_next;

    // Register writes, flush self-clear, read mux
    always_comb begin
        hp_next = hp_reg;
        rlow_next = rlow_reg;
        sc_next = sc_reg;
        if (wr_hp) begin
            hp_next = reg_wdata_i;
        end
        if (wr_rl) begin
            rlow_next = reg_wdata_i;
        end
        if (fl_last) begin
            sc_next[SC_FLUSH_BIT] = 1'b0;
        end
        if (wr_sc) begin
            // Writing zero to flush never aborts; a set beats the clear
            sc_next[SC_FLUSH_BIT] = reg_wdata_i[SC_FLUSH_BIT] ||
                sc_next[SC_FLUSH_BIT];
            sc_next[SC_FREEZE_BIT] = reg_wdata_i[SC_FREEZE_BIT];
            sc_next[SC_MASK_MSB:0] = reg_wdata_i[SC_MASK_MSB:0];
        end
        rvalid_next = reg_rd_i;
        case (reg_addr_i)
            HOST_PORT_AND_STORM_HIGH_OFS: rdata_next = hp_reg;
            STORM_RATE_LOW_OFS: rdata_next = rlow_reg;
            STAT_COUNTER_CONTROL_OFS: rdata_next = sc_reg;
            default: rdata_next = UNMAPPED_RD;
        endcase
        if (!reg_rd_i) begin
            rdata_next = reg_rdata_o;
        end
    end

    // Host port configuration and null VID substitution
    always_comb begin
        cfg_next.bp_en = hp_reg[HP_BP_BIT];
        cfg_next.half_duplex = hp_reg[HP_HALF_BIT];
        cfg_next.fc_en = hp_reg[HP_FC_BIT];
        cfg_next.speed_10 = hp_reg[HP_SPEED10_BIT];
        cfg_next.null_vid_repl = hp_reg[HP_NVR_BIT];
        vidv_next = vid_valid_i;
        vid_next = vid_o;
        if (vid_valid_i) begin
            vid_next = (hp_reg[HP_NVR_BIT] && vid_i == NULL_VID) ?
                port_vid_i : vid_i;
        end
    end

    // Flush walker, increment pipeline and counter readout
    always_comb begin
        fl_next = fl_reg;
        fl_addr_next = fl_addr_reg;
        fl_wr = 1'b0;
        fl_last = 1'b0;
        case (fl_reg)
            FL_IDLE: begin
                if (sc_reg[SC_FLUSH_BIT] && !inc_pend_reg) begin
                    fl_next = FL_RUN;
                    fl_addr_next = '0;
                end
            end
            FL_RUN: begin
                fl_wr = is_selected(fl_addr_reg[MIB_AW-1:MIB_IDX_W],
                    sc_reg[SC_MASK_MSB:0]);
                fl_addr_next = fl_addr_reg + 1'b1;
                if (fl_addr_reg == MIB_AW'(MIB_DEPTH - 1)) begin
                    fl_last = 1'b1;
                    fl_next = FL_IDLE;
                end
            end
            default: fl_next = FL_IDLE;
        endcase
        evt_addr = mib_addr(mib_evt_port_i, mib_evt_idx_i);
        evt_take = mib_evt_i && fl_reg == FL_IDLE && !sc_reg[SC_FLUSH_BIT]
            && mib_evt_port_i < 3'(NUM_PORTS)
            && mib_evt_idx_i < 6'(MIB_PER_PORT)
            && !(sc_reg[SC_FREEZE_BIT] && is_selected(mib_evt_port_i,
                sc_reg[SC_MASK_MSB:0]));
        rd_take = mib_rd_i && !evt_take;
        ram_rd_addr = evt_take ? evt_addr :
            mib_addr(mib_rd_port_i, mib_rd_idx_i);
        inc_pend_next = evt_take;
        inc_addr_next = evt_take ? evt_addr : inc_addr_reg;
        // Back-to-back events on one counter use the value just written
        fwd_next = evt_take && inc_pend_reg && evt_addr == inc_addr_reg;
        inc_data = (fwd_reg ? last_wr_reg : ram_rd_data) + 1'b1;
        ram_wr_en = fl_wr || inc_pend_reg;
        ram_wr_addr = fl_wr ? fl_addr_reg : inc_addr_reg;
        ram_wr_data = fl_wr ? '0 : inc_data;
        last_wr_next = inc_pend_reg ? inc_data : last_wr_reg;
        rd_pend_next = rd_take;
        mrv_next = rd_pend_reg;
        mrd_next = rd_pend_reg ? ram_rd_data : mib_rd_data_o;
        busy_next = (fl_next == FL_RUN);
    end

    // State registers
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            hp_reg <= HOST_PORT_RST;
            rlow_reg <= STORM_RATE_LOW_RST;
            sc_reg <= STAT_CTRL_RST;
            reg_rdata_o <= UNMAPPED_RD;
            reg_rvalid_o <= 1'b0;
            host_cfg_o <= '0;
            vid_valid_o <= 1'b0;
            vid_o <= '0;
            fl_reg <= FL_IDLE;
            fl_addr_reg <= '0;
            inc_pend_reg <= 1'b0;
            inc_addr_reg <= '0;
            fwd_reg <= 1'b0;
            last_wr_reg <= '0;
            rd_pend_reg <= 1'b0;
            mib_rd_valid_o <= 1'b0;
            mib_rd_data_o <= '0;
            mib_flush_busy_o <= 1'b0;
        end else begin
            hp_reg <= hp_next;
            rlow_reg <= rlow_next;
            sc_reg <= sc_next;
            reg_rdata_o <= rdata_next;
            reg_rvalid_o <= rvalid_next;
            host_cfg_o <= cfg_next;
            vid_valid_o <= vidv_next;
            vid_o <= vid_next;
            fl_reg <= fl_next;
            fl_addr_reg <= fl_addr_next;
            inc_pend_reg <= inc_pend_next;
            inc_addr_reg <= inc_addr_next;
            fwd_reg <= fwd_next;
            last_wr_reg <= last_wr_next;
            rd_pend_reg <= rd_pend_next;
            mib_rd_valid_o <= mrv_next;
            mib_rd_data_o <= mrd_next;
            mib_flush_busy_o <= busy_next;
        end
    end

    mib_counter_ram #(
        .AW(MIB_AW),
        .DW(MIB_DW),
        .DEPTH(MIB_DEPTH)
    ) u_ram (
        .clk_sys_i(clk_sys_i),
        .wr_en_i(ram_wr_en),
        .wr_addr_i(ram_wr_addr),
        .wr_data_i(ram_wr_data),
        .rd_addr_i(ram_rd_addr),
        .rd_data_o(ram_rd_data)
    );

    storm_limiter #(
        .NP(NUM_PORTS),
        .P100_CYC(P100_CYC),
        .P10_CYC(P10_CYC)
    ) u_storm (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .rate_i(rate),
        .block_i(bcast_block_i),
        .storm_en_i(port_storm_en_i),
        .speed_10_i(port_speed_10_i),
        .drop_o(bcast_drop_o)
    );

    // Checks on the register bank and counter control
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    property p_bp;
        wr_hp |=> ##1 host_cfg_o.bp_en == $past(reg_wdata_i[HP_BP_BIT], 2);
    endproperty
    a_bp: assert property (p_bp)
        else $error("back pressure enable does not follow register");

    property p_duplex;
        wr_hp |=> ##1 host_cfg_o.half_duplex ==
            $past(reg_wdata_i[HP_HALF_BIT], 2);
    endproperty
    a_duplex: assert property (p_duplex)
        else $error("duplex select does not follow register");

    property p_fc;
        wr_hp |=> ##1 host_cfg_o.fc_en == $past(reg_wdata_i[HP_FC_BIT], 2);
    endproperty
    a_fc: assert property (p_fc)
        else $error("flow control enable does not follow register");

    property p_speed;
        wr_hp |=> ##1 host_cfg_o.speed_10 ==
            $past(reg_wdata_i[HP_SPEED10_BIT], 2);
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed select does not follow register");

    property p_nvr;
        (vid_valid_i && hp_reg[HP_NVR_BIT] && vid_i == NULL_VID)
            |=> vid_valid_o && vid_o == $past(port_vid_i);
    endproperty
    a_nvr: assert property (p_nvr)
        else $error("null VID not replaced");

    property p_rate_rd;
        (reg_rd_i && reg_addr_i == STORM_RATE_LOW_OFS && !wr_rl)
            |=> reg_rvalid_o && reg_rdata_o == rate[7:0];
    endproperty
    a_rate_rd: assert property (p_rate_rd)
        else $error("storm rate low byte readback wrong");

    property p_flush_zero;
        (fl_reg == FL_RUN && is_selected(fl_addr_reg[MIB_AW-1:MIB_IDX_W],
            sc_reg[SC_MASK_MSB:0])) |-> ram_wr_en && ram_wr_data == '0;
    endproperty
    a_flush_zero: assert property (p_flush_zero)
        else $error("selected counter not zeroed");

    property p_flush_done;
        (fl_reg == FL_RUN && fl_addr_reg == MIB_AW'(MIB_DEPTH - 1) && !wr_sc)
            |=> !sc_reg[SC_FLUSH_BIT] && !mib_flush_busy_o;
    endproperty
    a_flush_done: assert property (p_flush_done)
        else $error("flush bit not cleared at completion");

    property p_freeze;
        (mib_evt_i && sc_reg[SC_FREEZE_BIT] && is_selected(mib_evt_port_i,
            sc_reg[SC_MASK_MSB:0])) |=> !inc_pend_reg;
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("frozen counter was incremented");

    c_flush: cover property (fl_reg == FL_RUN ##1 fl_reg == FL_IDLE);
    c_freeze: cover property (mib_evt_i && sc_reg[SC_FREEZE_BIT]);
    c_nvr: cover property (vid_valid_i && hp_reg[HP_NVR_BIT]
        && vid_i == NULL_VID);
endmodule
`default_nettype wire

// ===== logic/sw_ctrl_pkg.sv
// Shared constants and types of the switch global control register bank
package sw_ctrl_pkg;
    // Register offsets
    localparam logic [7:0] HOST_PORT_AND_STORM_HIGH_OFS = 8'h06;
    localparam logic [7:0] STORM_RATE_LOW_OFS = 8'h07;
    localparam logic [7:0] STAT_COUNTER_CONTROL_OFS = 8'h08;
    // Field positions in host_port_and_storm_high
    localparam int HP_BP_BIT = 7;
    localparam int HP_HALF_BIT = 6;
    localparam int HP_FC_BIT = 5;
    localparam int HP_SPEED10_BIT = 4;
    localparam int HP_NVR_BIT = 3;
    localparam int HP_RATE_HI_MSB = 2;
    // Field positions in stat_counter_control
    localparam int SC_FLUSH_BIT = 7;
    localparam int SC_FREEZE_BIT = 6;
    localparam int SC_MASK_MSB = 4;
    // Reset values
    localparam logic [7:0] HOST_PORT_RST = 8'h00;
    localparam logic [2:0] STORM_RATE_HIGH_RST = 3'h0;
    localparam logic [7:0] STORM_RATE_LOW_RST = 8'h4A;
    localparam logic [7:0] STAT_CTRL_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;
    // Ports, counters and widths
    localparam int NUM_PORTS = 5;
    localparam int RATE_W = 11;
    localparam int VID_W = 12;
    localparam int MIB_PER_PORT = 36;
    localparam int MIB_IDX_W = 6;
    localparam int MIB_PORT_W = 3;
    localparam int MIB_AW = MIB_PORT_W + MIB_IDX_W;
    localparam int MIB_DEPTH = NUM_PORTS * (1 << MIB_IDX_W);
    localparam int MIB_DW = 32;
    localparam logic [VID_W-1:0] NULL_VID = 12'h000;
    // Storm periods
    localparam int CLK_PERIOD_NS = 10;
    localparam int PERIOD_100_MS = 50;
    localparam int PERIOD_10_MS = 500;
    localparam int PERIOD_100_CYC = PERIOD_100_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PERIOD_10_CYC = PERIOD_10_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TIMER_W = 26;

    // Host-side port configuration
    typedef struct packed {
        logic bp_en;
        logic half_duplex;
        logic fc_en;
        logic speed_10;
        logic null_vid_repl;
    } host_cfg_t;

    typedef enum logic [0:0] {
        FL_IDLE = 1'b0,
        FL_RUN = 1'b1
    } flush_state_t;

    // Counter memory address from port and counter index
    function automatic logic [MIB_AW-1:0] mib_addr(
        input logic [MIB_PORT_W-1:0] port,
        input logic [MIB_IDX_W-1:0] idx);
        mib_addr = {port, idx};
    endfunction
endpackage

// ===== logic/mib_counter_ram.sv
// Counter storage for all ports, registered read data
`timescale 1ns/1ps
`default_nettype none
module mib_counter_ram #(
    parameter int AW = 9,
    parameter int DW = 32,
    parameter int DEPTH = 320
) (
    input wire logic clk_sys_i,            // System clock
    input wire logic wr_en_i,              // Write strobe
    input wire logic [AW-1:0] wr_addr_i,   // Write address
    input wire logic [DW-1:0] wr_data_i,   // Write data
    input wire logic [AW-1:0] rd_addr_i,   // Read address
    output logic [DW-1:0] rd_data_o        // Read data, one cycle later
);
    logic [DW-1:0] mem [DEPTH];

    // Write and registered read; read during write returns old data
    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule
`default_nettype wire

// ===== logic/storm_limiter.sv
// Per-port broadcast storm block counters and period timers
`timescale 1ns/1ps
`default_nettype none
module storm_limiter
    import sw_ctrl_pkg::*;
#(
    parameter int NP = 5,
    parameter int P100_CYC = 5000000,
    parameter int P10_CYC = 50000000
) (
    input wire logic clk_sys_i,                 // System clock
    input wire logic reset_n_i,                 // Sync reset, active low
    input wire logic [RATE_W-1:0] rate_i,       // Allowed blocks per period
    input wire logic [NP-1:0] block_i,          // 64-byte block seen, pulse
    input wire logic [NP-1:0] storm_en_i,       // Per-port protection enable
    input wire logic [NP-1:0] speed_10_i,       // Port runs at 10 Mb/s
    output logic [NP-1:0] drop_o                // Drop block, pulse
);
    logic [TIMER_W-1:0] t100_reg, t100_next, t10_reg, t10_next;
    logic tick100, tick10;
    logic [RATE_W-1:0] cnt_reg [NP];
    logic [RATE_W-1:0] cnt_next [NP];
    logic [NP-1:0] drop_next;

    // Period timers and per-port counters
    always_comb begin
        tick100 = (t100_reg == TIMER_W'(P100_CYC - 1));
        tick10 = (t10_reg == TIMER_W'(P10_CYC - 1));
        t100_next = tick100 ? '0 : t100_reg + 1'b1;
        t10_next = tick10 ? '0 : t10_reg + 1'b1;
        drop_next = '0;
        for (int p = 0; p < NP; p++) begin
            cnt_next[p] = cnt_reg[p];
            if (speed_10_i[p] ? tick10 : tick100) begin
                cnt_next[p] = '0;
            end
            if (block_i[p]) begin
                if (cnt_next[p] >= rate_i) begin
                    drop_next[p] = storm_en_i[p];
                end else begin
                    cnt_next[p] = cnt_next[p] + 1'b1;
                end
            end
        end
    end

    // State registers
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            t100_reg <= '0;
            t10_reg <= '0;
            drop_o <= '0;
            for (int p = 0; p < NP; p++) begin
                cnt_reg[p] <= '0;
            end
        end else begin
            t100_reg <= t100_next;
            t10_reg <= t10_next;
            drop_o <= drop_next;
            for (int p = 0; p < NP; p++) begin
                cnt_reg[p] <= cnt_next[p];
            end
        end
    end

    // Drop only when enabled and the allowance is used up
    property p_storm_drop;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (block_i[0] && storm_en_i[0] && !tick100 && !tick10
            && cnt_reg[0] >= rate_i) |=> drop_o[0];
    endproperty
    a_storm_drop: assert property (p_storm_drop)
        else $error("block over allowance not dropped");

    property p_storm_disabled;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        !storm_en_i[1] |=> !drop_o[1];
    endproperty
    a_storm_disabled: assert property (p_storm_disabled)
        else $error("drop on port without protection");

    c_storm_drop: cover property (@(posedge clk_sys_i) drop_o[0]);
endmodule
`default_nettype wire

// ===== dv/host_mac_model.sv
// Host-side traffic source: bursts of broadcast block pulses
`timescale 1ns/1ps
`default_nettype none
module host_mac_model (
    input wire logic clk_sys_i,     // Core clock
    input wire logic start_i,       // Start a burst, pulse
    input wire logic [4:0] ports_i, // Ports that send
    input wire logic [3:0] len_i,   // Blocks per port
    output logic [4:0] block_o      // One block per port per cycle
);
    logic [3:0] left_reg = 4'h0;
    logic [4:0] sel_reg = 5'h00;
    // Back-to-back blocks, the hardest case for the limiter
    always @(posedge clk_sys_i) begin
        if (start_i) begin
            left_reg <= len_i;
            sel_reg <= ports_i;
        end else if (left_reg != 4'h0) begin
            left_reg <= left_reg - 4'h1;
        end
    end
    assign block_o = (left_reg != 4'h0) ? sel_reg : 5'h00;
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench of the switch global control registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sw_ctrl_pkg::*;
    logic clk_sys_i, reset_n_i, wr, rd, rvalid, vv_i, vv_o, ev, mrd, mval;
    logic busy, start;
    logic [7:0] addr, wdata, rdata, d;
    logic [11:0] vid, pvid, vid_o;
    logic [4:0] blk, en, spd, drop;
    logic [2:0] ep, rp;
    logic [5:0] ei, ri;
    logic [31:0] mdata, m;
    host_cfg_t cfg;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    int drops [5] = '{default: 0};
    switch_global_control_regs #(.P100_CYC(20), .P10_CYC(200))
        switch_global_control_regs_inst (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .host_cfg_o(cfg), .vid_valid_i(vv_i),
        .vid_i(vid), .port_vid_i(pvid), .vid_valid_o(vv_o), .vid_o(vid_o),
        .bcast_block_i(blk), .port_storm_en_i(en), .port_speed_10_i(spd),
        .bcast_drop_o(drop), .mib_evt_i(ev), .mib_evt_port_i(ep),
        .mib_evt_idx_i(ei), .mib_rd_i(mrd), .mib_rd_port_i(rp),
        .mib_rd_idx_i(ri), .mib_rd_valid_o(mval), .mib_rd_data_o(mdata),
        .mib_flush_busy_o(busy));
    host_mac_model host_mac_model_inst (.clk_sys_i(clk_sys_i),
        .start_i(start), .ports_i(5'h07), .len_i(4'h3), .block_o(blk));
    // Clock generator
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // Cycle count after reset, drop tally and hang guard
    always @(posedge clk_sys_i) begin
        if (reset_n_i) cyc++;
        for (int p = 0; p < 5; p++) if (drop[p] === 1'b1) drops[p]++;
        if (cyc > 30000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Wait a bounded time for a valid pulse and insist that it comes
    task automatic wait_v(input int which);
        logic seen;
        seen = 1'b0;
        for (int n = 0; n < 4; n++) begin
            #1;
            seen = (which == 0 ? rvalid : which == 1 ? vv_o : mval) === 1'b1;
            if (seen) break;
            @(posedge clk_sys_i);
        end
        check(seen, 1'b1);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        wait_v(0);
        v = rdata;
    endtask
    task automatic vid_chk(input logic [7:0] c, input logic [11:0] vin,
                           input logic [11:0] e);
        reg_wr(8'h06, c);
        vid <= vin;
        pvid <= 12'h5A3;
        vv_i <= 1'b1;
        @(posedge clk_sys_i);
        vv_i <= 1'b0;
        wait_v(1);
        check(vid_o, e);
    endtask
    task automatic mib_op(input logic r, input logic [2:0] p,
                          input logic [5:0] i);
        @(posedge clk_sys_i);
        {ep, ei, rp, ri} <= {p, i, p, i};
        if (r) mrd <= 1'b1;
        else ev <= 1'b1;
        @(posedge clk_sys_i);
        {ev, mrd} <= 2'b00;
        if (r) wait_v(2);
        m = mdata;
    endtask
    // Start a flush and poll until the flush bit drops
    task automatic flush(input logic [7:0] c);
        reg_wr(8'h08, c);
        check(busy, 1'b1);
        for (int n = 0; n < 400; n++) begin
            reg_rd(8'h08, d);
            if (d[7] === 1'b0) break;
        end
        check(d, {3'h0, c[4:0]});
        check(busy, 1'b0);
    endtask
    task automatic storm_burst(input int phase);
        while (cyc % 200 != phase) @(posedge clk_sys_i);
        start <= 1'b1;
        @(posedge clk_sys_i);
        start <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
    endtask
    initial begin
        {wr, rd, vv_i, ev, mrd, start} = 6'h00;
        {addr, wdata, vid, pvid, ep, ei, rp, ri} = 0;
        en = 5'h05;
        spd = 5'h04;
        reset_n_i = 1'b0;
        repeat (20) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        reg_rd(8'h06, d);
        check(d, 8'h00);
        reg_rd(8'h07, d);
        check(d, 8'h4A);
        reg_rd(8'h09, d);
        check(d, 8'h00);
        for (int k = 0; k < 5; k++) begin
            reg_wr(8'h06, 8'h80 >> k);
            check(cfg, 5'h10 >> k);
        end
        reg_wr(8'h06, 8'h05);
        reg_wr(8'h07, 8'h02);
        reg_rd(8'h06, d);
        check(d, 8'h05);
        vid_chk(8'h08, 12'h000, 12'h5A3);
        vid_chk(8'h08, 12'h010, 12'h010);
        vid_chk(8'h00, 12'h000, 12'h000);
        // Rate 2: port0 100M, port1 unprotected, port2 10M
        storm_burst(5);
        storm_burst(45);
        check(drops[0], 2);
        check(drops[1], 0);
        check(drops[2], 4);
        flush(8'h9F);
        mib_op(0, 3'h1, 6'h03);
        mib_op(0, 3'h1, 6'h03);
        mib_op(0, 3'h4, 6'h00);
        reg_wr(8'h08, 8'h42);
        mib_op(0, 3'h1, 6'h03);
        mib_op(0, 3'h4, 6'h00);
        mib_op(1, 3'h1, 6'h03);
        check(m, 2);
        mib_op(1, 3'h4, 6'h00);
        check(m, 2);
        flush(8'h82);
        mib_op(1, 3'h1, 6'h03);
        check(m, 0);
        mib_op(1, 3'h4, 6'h00);
        check(m, 2);
        tally_and_finish();
    end
endmodule
`default_nettype wire
